// [shared/vtp_defines.svh]
`ifndef VTP_DEFINES_SVH
`define VTP_DEFINES_SVH

// word and address widths of the table memory, and the table length field
`define VTP_WORD_W  16
`define VTP_ADDR_W  16
`define VTP_LEN_W   8

// pointer constants
`define VTP_PTR_ZERO 16'h0000
`define VTP_PTR_STEP 16'h0001
`define VTP_PTR_WRAP 16'h0001

// first data word sits one word above the pointer word
`define VTP_DATA_OFS 16'h0001

`endif

// [shared/vtp_pkg.sv]
`include "vtp_defines.svh"

package vtp_pkg;

	typedef logic [`VTP_WORD_W-1:0] vtp_word_t;
	typedef logic [`VTP_ADDR_W-1:0] vtp_addr_t;
	typedef logic [`VTP_LEN_W-1:0]  vtp_len_t;

	typedef enum logic {
		VTP_OP_REMOVE_FROM_BOTTOM,
		VTP_OP_SOURCE_TO_TABLE
	} vtp_op_t;

	typedef enum {
		VTP_S_IDLE,
		VTP_S_GET_PTR,
		VTP_S_GET_DATA,
		VTP_S_WR_PTR,
		VTP_S_DONE
	} vtp_state_t;

	// one execution request from the program
	typedef struct packed {
		vtp_op_t   op;
		logic      en;
		vtp_addr_t base;
		vtp_len_t  len;
		vtp_addr_t addr;
	} vtp_req_t;

	// word memory port, read data is valid in the same cycle as rd
	typedef struct packed {
		logic      rd;
		logic      wr;
		vtp_addr_t addr;
		vtp_word_t wdata;
	} vtp_mem_t;

	typedef struct packed {
		vtp_state_t st;
		vtp_op_t    op;
		vtp_addr_t  base;
		vtp_len_t   len;
		vtp_addr_t  addr;
		vtp_word_t  ptr;
		vtp_word_t  nptr;
		vtp_addr_t  tgt;
		vtp_mem_t   mem;
		logic       done;
		logic       flag;
	} vtp_regs_t;

	function automatic vtp_word_t vtp_len_word(input vtp_len_t len);
		vtp_len_word = {{(`VTP_WORD_W-`VTP_LEN_W){1'b0}}, len};
	endfunction : vtp_len_word

	function automatic vtp_addr_t vtp_offset(input vtp_addr_t base, input vtp_word_t ofs);
		vtp_offset = base + ofs;
	endfunction : vtp_offset

endpackage : vtp_pkg

// [logic/vtp_table_pointer_mover.sv]
`timescale 1ns/1ps
`include "vtp_defines.svh"

module vtp_table_pointer_mover
	import vtp_pkg::*;
#(
	parameter int WORD_W = `VTP_WORD_W,
	parameter int ADDR_W = `VTP_ADDR_W,
	parameter int LEN_W  = `VTP_LEN_W
) (
	input  wire logic      mclk_i,
	input  wire logic      rst_i,
	input  wire logic      req_valid_i,
	input  wire vtp_req_t  req_i,
	output logic           req_ready_o,
	input  wire logic      scan_end_i,
	input  wire vtp_word_t mem_rdata_i,
	output vtp_mem_t       mem_o,
	output logic           done_o,
	output logic           table_status_flag_o
);

	////////////////////////////////////////////////////////////////////////////////
	// widths are fixed by the package types; refuse anything else

	if (WORD_W != `VTP_WORD_W || ADDR_W != `VTP_ADDR_W || LEN_W != `VTP_LEN_W) begin : g_chk
		$error("vtp: widths must match the package types");
	end

	////////////////////////////////////////////////////////////////////////////////

	vtp_regs_t r_reg;
	vtp_regs_t r_next;
	logic      flag_set;
	logic      flag_clr;
	vtp_word_t len_w;

	assign len_w = vtp_len_word(r_reg.len);

	always_comb begin
		r_next       = r_reg;
		r_next.mem.rd = 1'b0;
		r_next.mem.wr = 1'b0;
		r_next.done  = 1'b0;
		flag_set     = 1'b0;
		flag_clr     = 1'b0;
		unique case (r_reg.st)
			VTP_S_IDLE: begin
				if (req_valid_i) begin
					r_next.op   = req_i.op;
					r_next.base = req_i.base;
					r_next.len  = req_i.len;
					r_next.addr = req_i.addr;
					if (req_i.en) begin
						r_next.mem.rd   = 1'b1;
						r_next.mem.addr = req_i.base;
						r_next.st       = VTP_S_GET_PTR;
						// a new flag user invalidates the old result
						flag_clr        = 1'b1;
					end else begin
						r_next.done = 1'b1;
					end
				end
			end
			VTP_S_GET_PTR: begin
				r_next.ptr = mem_rdata_i;
				r_next.st  = VTP_S_DONE;
				if (r_reg.op == VTP_OP_REMOVE_FROM_BOTTOM) begin
					if (mem_rdata_i == `VTP_PTR_ZERO) begin
						flag_set = 1'b1;
					end else if (mem_rdata_i <= len_w) begin
						r_next.mem.rd   = 1'b1;
						r_next.mem.addr = vtp_offset(r_reg.base, mem_rdata_i);
						r_next.tgt      = r_reg.addr;
						r_next.nptr     = mem_rdata_i - `VTP_PTR_STEP;
						r_next.st       = VTP_S_GET_DATA;
					end
				end else if (mem_rdata_i <= len_w) begin
					r_next.mem.rd   = 1'b1;
					r_next.mem.addr = r_reg.addr;
					r_next.st       = VTP_S_GET_DATA;
					if (mem_rdata_i == `VTP_PTR_ZERO || mem_rdata_i == len_w) begin
						r_next.tgt = vtp_offset(r_reg.base, `VTP_DATA_OFS);
					end else begin
						r_next.tgt = vtp_offset(r_reg.base, mem_rdata_i + `VTP_DATA_OFS);
					end
					r_next.nptr = (mem_rdata_i == len_w) ? `VTP_PTR_WRAP
						: mem_rdata_i + `VTP_PTR_STEP;
				end
			end
			VTP_S_GET_DATA: begin
				r_next.mem.wr    = 1'b1;
				r_next.mem.addr  = r_reg.tgt;
				r_next.mem.wdata = mem_rdata_i;
				r_next.st        = VTP_S_WR_PTR;
			end
			VTP_S_WR_PTR: begin
				// pointer is written only after the data move
				r_next.mem.wr    = 1'b1;
				r_next.mem.addr  = r_reg.base;
				r_next.mem.wdata = r_reg.nptr;
				r_next.st        = VTP_S_DONE;
				if (r_reg.op == VTP_OP_REMOVE_FROM_BOTTOM) begin
					flag_set = (r_reg.nptr == `VTP_PTR_ZERO);
				end else begin
					flag_set = (r_reg.nptr == len_w);
				end
			end
			VTP_S_DONE: begin
				r_next.done = 1'b1;
				r_next.st   = VTP_S_IDLE;
			end
		endcase
		// set wins over an end of scan in the same cycle
		if (flag_set) begin
			r_next.flag = 1'b1;
		end else if (flag_clr || scan_end_i) begin
			r_next.flag = 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			r_reg <= '{st: VTP_S_IDLE, op: VTP_OP_REMOVE_FROM_BOTTOM, default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign req_ready_o         = (r_reg.st == VTP_S_IDLE);
	assign mem_o               = r_reg.mem;
	assign done_o              = r_reg.done;
	assign table_status_flag_o = r_reg.flag;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_ptr_read;
		@(posedge mclk_i) disable iff (rst_i)
		req_valid_i && req_ready_o && req_i.en
			|=> mem_o.rd && !mem_o.wr && mem_o.addr == $past(req_i.base);
	endproperty
	a_ptr_read: assert property (p_ptr_read) else $error("pointer word not read at base");

	property p_no_exec;
		@(posedge mclk_i) disable iff (rst_i)
		req_valid_i && req_ready_o && !req_i.en |=> done_o && !mem_o.rd && !mem_o.wr;
	endproperty
	a_no_exec: assert property (p_no_exec) else $error("disabled request touched memory");

	property p_rfb_addr;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_GET_PTR && r_reg.op == VTP_OP_REMOVE_FROM_BOTTOM
			&& mem_rdata_i != `VTP_PTR_ZERO && mem_rdata_i <= len_w
			|=> mem_o.rd && mem_o.addr == r_reg.base + r_reg.ptr;
	endproperty
	a_rfb_addr: assert property (p_rfb_addr) else $error("wrong table word read");

	property p_rfb_dec;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_GET_PTR && r_reg.op == VTP_OP_REMOVE_FROM_BOTTOM
			&& mem_rdata_i != `VTP_PTR_ZERO && mem_rdata_i <= len_w
			|=> ##1 mem_o.wr ##1 mem_o.wr && mem_o.wdata == $past(r_reg.ptr, 2) - `VTP_PTR_STEP;
	endproperty
	a_rfb_dec: assert property (p_rfb_dec) else $error("pointer not lowered by one");

	property p_rfb_zero;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_GET_PTR && r_reg.op == VTP_OP_REMOVE_FROM_BOTTOM
			&& mem_rdata_i == `VTP_PTR_ZERO
			|=> table_status_flag_o && !mem_o.rd && !mem_o.wr ##1 done_o && !mem_o.wr;
	endproperty
	a_rfb_zero: assert property (p_rfb_zero) else $error("move at pointer zero");

	property p_out_of_range;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_GET_PTR && mem_rdata_i > len_w |=> !mem_o.rd && !mem_o.wr ##1 done_o;
	endproperty
	a_out_of_range: assert property (p_out_of_range) else $error("move outside table");

	property p_stt_wrap;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_GET_PTR && r_reg.op == VTP_OP_SOURCE_TO_TABLE && mem_rdata_i == len_w
			|=> ##1 mem_o.addr == r_reg.base + `VTP_DATA_OFS
			##1 mem_o.wdata == `VTP_PTR_WRAP && table_status_flag_o == (len_w == `VTP_PTR_WRAP);
	endproperty
	a_stt_wrap: assert property (p_stt_wrap) else $error("pointer did not wrap to one");

	property p_stt_flag;
		@(posedge mclk_i) disable iff (rst_i)
		r_reg.st == VTP_S_WR_PTR && r_reg.op == VTP_OP_SOURCE_TO_TABLE
			|=> table_status_flag_o == ($past(r_reg.nptr) == $past(len_w));
	endproperty
	a_stt_flag: assert property (p_stt_flag) else $error("flag wrong after store");

	property p_scan_clear;
		@(posedge mclk_i) disable iff (rst_i)
		scan_end_i && !flag_set |=> !table_status_flag_o;
	endproperty
	a_scan_clear: assert property (p_scan_clear) else $error("flag outlived the scan");

endmodule : vtp_table_pointer_mover

// [testbench/vtp_word_mem.sv]
`timescale 1ns/1ps
module vtp_word_mem
	import vtp_pkg::*;
(
	input  wire logic     mclk_i,
	input  wire vtp_mem_t mem_i,
	output vtp_word_t     rdata_o
);
	vtp_word_t m [512];
	// the mover takes read data at the edge that ends its read strobe, so data follows
	// the strobe within the cycle; without a strobe the bus shows the inverse word
	// so that stale data never looks valid
	assign rdata_o = mem_i.rd ? m[mem_i.addr[8:0]] : ~m[mem_i.addr[8:0]];
	always @(posedge mclk_i) begin
		if (mem_i.wr) begin
			m[mem_i.addr[8:0]] <= mem_i.wdata;
		end
	end
endmodule : vtp_word_mem

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import vtp_pkg::*;
	logic        mclk_i, rst_i, req_valid_i, scan_end_i;
	logic        req_ready_o, done_o, table_status_flag_o;
	vtp_req_t    req_i;
	vtp_mem_t    mem_o;
	vtp_word_t   mem_rdata_i;
	int          mismatches, n_checks, ref_flag, ref_m [512];
	logic [31:0] seed = 32'h00005dbf;
	logic [31:0] r;

	vtp_table_pointer_mover uut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_ready_o(req_ready_o), .scan_end_i(scan_end_i),
		.mem_rdata_i(mem_rdata_i), .mem_o(mem_o), .done_o(done_o),
		.table_status_flag_o(table_status_flag_o));
	vtp_word_mem mem (.mclk_i(mclk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk_w(input vtp_word_t got, input vtp_word_t exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t word %h exp %h", $time, got, exp);
		end
	endtask : chk_w

	task automatic chk_f(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
		end
	endtask : chk_f

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop

	task automatic setp(input int a, input int v);
		ref_m[a] = v & 32'h0000ffff;
		mem.m[a] = v[15:0];
	endtask : setp

	task automatic ref_exec(input vtp_op_t op, input bit en, input int b, input int len, input int a);
		int p;
		if (!en) return;
		ref_flag = 0;
		p = ref_m[b];
		if (op == VTP_OP_REMOVE_FROM_BOTTOM) begin
			if (p == 0) ref_flag = 1;
			else if (p <= len) begin
				ref_m[a] = ref_m[b + p];
				ref_m[b] = p - 1;
				ref_flag = (p == 1);
			end
		end else if (p <= len) begin
			ref_m[(p == 0 || p == len) ? b + 1 : b + p + 1] = ref_m[a];
			ref_m[b] = (p == len) ? 1 : p + 1;
			ref_flag = (ref_m[b] == len);
		end
	endtask : ref_exec

	// request is taken at the first edge since ready is high when idle
	task automatic run(input vtp_op_t op, input bit en, input int b, input int len, input int a);
		int n;
		req_i = {op, en, b[15:0], len[7:0], a[15:0]};
		chk_f(req_ready_o, 1'b1);
		req_valid_i = 1'b1;
		@(posedge mclk_i);
		#1 req_valid_i = 1'b0;
		ref_exec(op, en, b, len, a);
		n = 0;
		@(negedge mclk_i);
		while (done_o !== 1'b1 && n < 12) begin
			@(negedge mclk_i);
			n++;
		end
		chk_f(done_o, 1'b1);
		chk_f(table_status_flag_o, ref_flag[0]);
		for (int i = 0; i < 512; i++) chk_w(mem.m[i], ref_m[i][15:0]);
		@(posedge mclk_i);
		#1;
	endtask : run

	initial begin
		rst_i = 1'b1;
		req_valid_i = 1'b0;
		scan_end_i = 1'b0;
		req_i = '0;
		ref_flag = 0;
		for (int i = 0; i < 512; i++) setp(i, xs());
		repeat (3) @(posedge mclk_i);
		#1 rst_i = 1'b0;
		chk_f(table_status_flag_o, 1'b0);
		setp(16, 6);
		repeat (8) run(VTP_OP_REMOVE_FROM_BOTTOM, 1, 16, 6, 200);
		scan_end_i = 1'b1;
		@(posedge mclk_i);
		#1 scan_end_i = 1'b0;
		ref_flag = 0;
		chk_f(table_status_flag_o, 1'b0);
		setp(16, 7);
		run(VTP_OP_REMOVE_FROM_BOTTOM, 1, 16, 6, 200);
		setp(16, 0);
		run(VTP_OP_REMOVE_FROM_BOTTOM, 1, 16, 6, 200);
		run(VTP_OP_REMOVE_FROM_BOTTOM, 0, 16, 6, 200);
		setp(40, 0);
		repeat (14) begin
			setp(300, xs());
			run(VTP_OP_SOURCE_TO_TABLE, 1, 40, 6, 300);
		end
		setp(40, 9);
		run(VTP_OP_SOURCE_TO_TABLE, 1, 40, 6, 300);
		// widest table the length field allows
		setp(256, 255);
		run(VTP_OP_SOURCE_TO_TABLE, 1, 256, 255, 300);
		setp(256, 255);
		run(VTP_OP_REMOVE_FROM_BOTTOM, 1, 256, 255, 200);
		setp(80, 3);
		repeat (24) begin
			r = xs();
			setp(300, xs());
			run(vtp_op_t'(r[8]), r[9], 80, 5, 300);
		end
		report_and_stop();
	end

	initial begin
		#100000;
		mismatches++;
		report_and_stop();
	end
endmodule : tb_top
